/* ssc_map.svh */
// Offsets, field positions, reset values and repeat counts for the segment sequencer.
// Assumes inclusion by bare name; definitions only.
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH

// ----------------------------------------
// Register offsets (word addresses)
// ----------------------------------------
`define SSC_REG_CTRL 4'h0
`define SSC_REG_REPEAT 4'h1
`define SSC_REG_TBL_ADDR 4'h2
`define SSC_REG_TBL_DATA 4'h3
`define SSC_REG_CMD 4'h4
`define SSC_REG_STATUS 4'h5
`define SSC_REG_SEQ_LOOPS 4'h6

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SSC_CTRL_MODE_LSB 0
`define SSC_CTRL_SRC_LSB 2
`define SSC_CTRL_ARM_BIT 4
`define SSC_CTRL_OUT_EN_BIT 5
`define SSC_CTRL_RESET 32'h0000_0000

// ----------------------------------------
// Command register bits
// ----------------------------------------
`define SSC_CMD_START_BIT 0
`define SSC_CMD_STOP_BIT 1
`define SSC_CMD_SOFT_EVENT_BIT 2
`define SSC_CMD_RECALL_BIT 3

// ----------------------------------------
// Table row layout
// ----------------------------------------
`define SSC_ROW_LOOPS_LSB 0
`define SSC_ROW_SEG_LSB 20
`define SSC_ROW_JUMP_BIT 28
`define SSC_ROW_LINK_LSB 29

// ----------------------------------------
// Counts
// ----------------------------------------
`define SSC_REPEAT_MAX 20'd1000000
`define SSC_REPEAT_RESET 20'd1

`endif

/* ssc_pkg.sv */
// Types shared by the segment sequencer.
// Assumes the map header is included where offsets are needed.
package ssc_pkg;
   typedef enum logic [1:0] {MODE_AUTO, MODE_ONCE, MODE_STEPPED} ssc_mode_t;
   typedef enum logic [1:0] {SRC_BUTTON, SRC_TRIGGER, SRC_EVENT, SRC_SOFT} ssc_src_t;
   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_PLAY} ssc_state_t;

   // One sequence table row
   typedef struct packed {
      logic [2:0] link;
      logic jump;
      logic [7:0] segment;
      logic [19:0] loops;
   } ssc_row_t;

   // Request to the segment player
   typedef struct packed {
      logic [7:0] segment;
      logic last_pass;
   } ssc_seg_req_t;
endpackage

/* ssc_sequencer.sv */
// Segment sequencer for one output channel: walks a loaded table, issues segments.
// Assumes a segment player that pulses seg_done_i when a pass ends and pins synced here.
`timescale 1ns/100ps
`default_nettype none
`include "ssc_map.svh"

module ssc_sequencer #(
   parameter int ROWS = 8,
   parameter int RW = $clog2(ROWS)
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic manual_trigger_button,
   input wire logic trig_in,
   input wire logic event_in,
   input wire logic seg_done_i,
   output logic seg_valid_o,
   input wire logic seg_ready_i,
   output ssc_pkg::ssc_seg_req_t seg_o,
   output logic output_en_o,
   output logic playing_o
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      ssc_pkg::ssc_state_t st;
      ssc_pkg::ssc_mode_t mode;
      ssc_pkg::ssc_src_t src;
      logic arm;
      logic out_en;
      logic [19:0] repeat_cfg;
      logic [19:0] repeat_cnt;
      logic [RW-1:0] tbl_addr;
      logic [RW-1:0] row;
      logic [19:0] loop_cnt;
      logic [19:0] seq_loops_cfg;
      logic [19:0] seq_cnt;
      logic [RW-1:0] sub_start;
      logic [2:0] sync_btn;
      logic [2:0] sync_trg;
      logic [2:0] sync_evt;
      logic soft_evt;
      logic jump_pending;
      logic [1:0] buf_vld;
      ssc_pkg::ssc_seg_req_t [1:0] buf_dat;
      logic [31:0] rdata;
      logic [RW:0] inflight;
   } ssc_state_s_t;

   ssc_state_s_t s_q, s_d;
   ssc_pkg::ssc_row_t table_q [ROWS];

   // Row is emitted with loop count reloaded on entry
   function automatic logic [19:0] row_loops(input ssc_pkg::ssc_row_t r);
      row_loops = (r.loops == 20'h0_0000) ? 20'h0_0001 : r.loops;
   endfunction

   ssc_pkg::ssc_row_t cur_row;
   logic adv_evt, go_evt, issue, last_row, wr_tbl;
   logic btn_rise, trg_rise, evt_rise;

   assign cur_row = table_q[s_q.row];
   assign last_row = (s_q.row == RW'(ROWS - 1));
   assign btn_rise = s_q.sync_btn[1] & ~s_q.sync_btn[2];
   assign trg_rise = s_q.sync_trg[1] & ~s_q.sync_trg[2];
   assign evt_rise = s_q.sync_evt[1] & ~s_q.sync_evt[2];
   assign wr_tbl = reg_wr && (reg_addr == `SSC_REG_TBL_DATA);

   // ----------------------------------------
   // Advance source select
   // ----------------------------------------
   always_comb begin
      unique case (s_q.src)
         ssc_pkg::SRC_BUTTON: adv_evt = btn_rise;
         ssc_pkg::SRC_TRIGGER: adv_evt = trg_rise;
         ssc_pkg::SRC_EVENT: adv_evt = evt_rise;
         ssc_pkg::SRC_SOFT: adv_evt = s_q.soft_evt;
      endcase
   end

   assign go_evt = adv_evt;
   // Refill the two-entry buffer whenever a slot is free so the player never starves
   assign issue = (s_q.st == ssc_pkg::ST_PLAY) && !(&s_q.buf_vld);

   always_ff @(posedge clock) begin
      if (wr_tbl) begin
         table_q[s_q.tbl_addr] <= reg_wdata;
      end
   end

   always_comb begin
      s_d = s_q;
      s_d.sync_btn = {s_q.sync_btn[1:0], manual_trigger_button};
      s_d.sync_trg = {s_q.sync_trg[1:0], trig_in};
      s_d.sync_evt = {s_q.sync_evt[1:0], event_in};
      s_d.soft_evt = 1'b0;
      s_d.rdata = 32'h0000_0000;

      // ----------------------------------------
      // Register bus
      // ----------------------------------------
      if (reg_wr) begin
         unique case (reg_addr)
            `SSC_REG_CTRL: begin
               s_d.mode = ssc_pkg::ssc_mode_t'(reg_wdata[`SSC_CTRL_MODE_LSB +: 2]);
               s_d.src = ssc_pkg::ssc_src_t'(reg_wdata[`SSC_CTRL_SRC_LSB +: 2]);
               s_d.arm = reg_wdata[`SSC_CTRL_ARM_BIT];
               s_d.out_en = reg_wdata[`SSC_CTRL_OUT_EN_BIT];
            end
            `SSC_REG_REPEAT: begin
               // Whole word is compared so large values clamp instead of wrapping
               if (reg_wdata == 32'h0000_0000) begin
                  s_d.repeat_cfg = `SSC_REPEAT_RESET;
               end else if (reg_wdata > {12'h000, `SSC_REPEAT_MAX}) begin
                  s_d.repeat_cfg = `SSC_REPEAT_MAX;
               end else begin
                  s_d.repeat_cfg = reg_wdata[19:0];
               end
            end
            `SSC_REG_TBL_ADDR: s_d.tbl_addr = reg_wdata[RW-1:0];
            `SSC_REG_TBL_DATA: s_d.tbl_addr = s_q.tbl_addr + RW'(1);
            `SSC_REG_SEQ_LOOPS: s_d.seq_loops_cfg = reg_wdata[19:0];
            `SSC_REG_CMD: begin
               s_d.soft_evt = reg_wdata[`SSC_CMD_SOFT_EVENT_BIT];
               if (reg_wdata[`SSC_CMD_RECALL_BIT]) begin
                  s_d.out_en = 1'b0;
               end
               if (reg_wdata[`SSC_CMD_STOP_BIT]) begin
                  s_d.st = ssc_pkg::ST_IDLE;
               end else if (reg_wdata[`SSC_CMD_START_BIT]) begin
                  s_d.st = ssc_pkg::ST_ARMED;
                  s_d.row = '0;
                  s_d.loop_cnt = row_loops(table_q[0]);
                  s_d.seq_cnt = s_q.seq_loops_cfg;
                  s_d.sub_start = '0;
                  s_d.repeat_cnt = s_q.repeat_cfg;
                  s_d.jump_pending = 1'b0;
               end
            end
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            `SSC_REG_CTRL: s_d.rdata = {26'h0, s_q.out_en, s_q.arm, s_q.src, s_q.mode};
            `SSC_REG_REPEAT: s_d.rdata = {12'h0, s_q.repeat_cfg};
            `SSC_REG_TBL_ADDR: s_d.rdata = 32'(s_q.tbl_addr);
            `SSC_REG_TBL_DATA: s_d.rdata = table_q[s_q.tbl_addr];
            `SSC_REG_SEQ_LOOPS: s_d.rdata = {12'h0, s_q.seq_loops_cfg};
            `SSC_REG_STATUS: s_d.rdata = {8'(s_q.row), 4'(s_q.repeat_cnt[3:0]), 18'h0, s_q.st};
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end

      // ----------------------------------------
      // Sequencer
      // ----------------------------------------
      unique case (s_q.st)
         ssc_pkg::ST_IDLE: ;
         ssc_pkg::ST_ARMED: begin
            // Armed waits for the selected source; unarmed auto starts at once
            if (!s_q.arm && s_q.mode == ssc_pkg::MODE_AUTO) begin
               s_d.st = ssc_pkg::ST_PLAY;
            end else if (go_evt) begin
               s_d.st = ssc_pkg::ST_PLAY;
            end
         end
         ssc_pkg::ST_PLAY: begin
            if (go_evt && (cur_row.jump || s_q.mode == ssc_pkg::MODE_STEPPED)) begin
               s_d.jump_pending = 1'b1;
            end
            if (issue) begin
               s_d.buf_vld[1] = s_q.buf_vld[0];
               s_d.buf_dat[1] = s_q.buf_dat[0];
               s_d.buf_vld[0] = 1'b1;
               s_d.buf_dat[0].segment = cur_row.segment;
               s_d.buf_dat[0].last_pass = (s_q.loop_cnt == 20'h0_0001);
               if (s_q.loop_cnt > 20'h0_0001) begin
                  s_d.loop_cnt = s_q.loop_cnt - 20'h0_0001;
               end else if ((cur_row.jump || s_q.mode == ssc_pkg::MODE_STEPPED) && !s_d.jump_pending) begin
                  s_d.loop_cnt = 20'h0_0001;
               end else begin
                  s_d.jump_pending = 1'b0;
                  if (cur_row.link != 3'h0 && s_q.seq_cnt > 20'h0_0001) begin
                     // Row with a link closes a sub-sequence that repeats
                     s_d.seq_cnt = s_q.seq_cnt - 20'h0_0001;
                     s_d.row = s_q.sub_start;
                     s_d.loop_cnt = row_loops(table_q[s_q.sub_start]);
                  end else if (last_row) begin
                     s_d.row = '0;
                     s_d.sub_start = '0;
                     s_d.seq_cnt = s_q.seq_loops_cfg;
                     s_d.loop_cnt = row_loops(table_q[0]);
                     if (s_q.mode == ssc_pkg::MODE_ONCE) begin
                        if (s_q.repeat_cnt > 20'h0_0001) begin
                           s_d.repeat_cnt = s_q.repeat_cnt - 20'h0_0001;
                        end else begin
                           s_d.repeat_cnt = s_q.repeat_cfg;
                           s_d.st = ssc_pkg::ST_ARMED;
                        end
                     end
                  end else begin
                     s_d.row = s_q.row + RW'(1);
                     s_d.loop_cnt = row_loops(table_q[s_q.row + RW'(1)]);
                     if (cur_row.link != 3'h0) begin
                        s_d.sub_start = s_q.row + RW'(1);
                        s_d.seq_cnt = s_q.seq_loops_cfg;
                     end
                  end
               end
            end
         end
         default: s_d.st = ssc_pkg::ST_IDLE;
      endcase

      // ----------------------------------------
      // Two-entry output buffer: drain oldest
      // ----------------------------------------
      if (seg_valid_o && seg_ready_i) begin
         if (s_d.buf_vld[1]) begin
            s_d.buf_vld[1] = 1'b0;
         end else begin
            s_d.buf_vld[0] = 1'b0;
         end
      end
      if (s_d.st == ssc_pkg::ST_IDLE) begin
         s_d.buf_vld = 2'b00;
      end
      s_d.inflight = seg_done_i ? '0 : s_q.inflight;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s_q <= '0;
         s_q.repeat_cfg <= `SSC_REPEAT_RESET;
         s_q.repeat_cnt <= `SSC_REPEAT_RESET;
         s_q.seq_loops_cfg <= 20'h0_0001;
         s_q.loop_cnt <= 20'h0_0001;
         s_q.seq_cnt <= 20'h0_0001;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   logic seg_valid_q;
   ssc_pkg::ssc_seg_req_t seg_q;
   logic out_en_q, playing_q;
   always_ff @(posedge clock) begin
      if (rst) begin
         out_en_q <= 1'b0;
         playing_q <= 1'b0;
      end else begin
         out_en_q <= s_d.out_en;
         playing_q <= (s_d.st == ssc_pkg::ST_PLAY);
      end
   end
   assign seg_valid_o = s_q.buf_vld[1] | s_q.buf_vld[0];
   assign seg_o = s_q.buf_vld[1] ? s_q.buf_dat[1] : s_q.buf_dat[0];
   assign reg_rdata = s_q.rdata;
   assign output_en_o = out_en_q;
   assign playing_o = playing_q;

endmodule // ssc_sequencer
`default_nettype wire

/* ssc_sequencer_props.sv */
// Port checker for the segment sequencer.
// Assumes it is bound onto every ssc_sequencer instance.
`timescale 1ns/100ps
`default_nettype none
`include "ssc_map.svh"
module ssc_sequencer_props (
   input wire logic clock,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic seg_ready_i,
   input wire logic seg_valid_o,
   input wire ssc_pkg::ssc_seg_req_t seg_o,
   input wire logic output_en_o,
   input wire logic playing_o
);
   // ------------------------------
   // Port relations
   // ------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   wire logic cmd_wr = reg_wr && reg_addr == `SSC_REG_CMD;
   wire logic ctrl_on = reg_wr && reg_addr == `SSC_REG_CTRL && reg_wdata[`SSC_CTRL_OUT_EN_BIT];
   reset_quiet_a: assert property ($fell(rst) |-> !seg_valid_o && !output_en_o && !playing_o)
      else $error("outputs active after reset");
   read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside read slot");
   unmapped_a: assert property (reg_rd && reg_addr > 4'h6 |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   hold_req_a: assert property (seg_valid_o && !seg_ready_i |=> seg_valid_o && $stable(seg_o))
      else $error("request changed while stalled");
   recall_off_a: assert property (cmd_wr && reg_wdata[`SSC_CMD_RECALL_BIT] |-> ##[1:2] !output_en_o)
      else $error("output on after recall");
   out_on_a: assert property (ctrl_on |-> ##[1:2] output_en_o)
      else $error("output enable not taken");
   play_status_a: assert property (reg_rd && reg_addr == `SSC_REG_STATUS && playing_o |=> reg_rdata[1:0] == 2'h2)
      else $error("status disagrees with play");
   stop_halt_a: assert property (cmd_wr && reg_wdata[`SSC_CMD_STOP_BIT] |-> ##[1:3] !playing_o)
      else $error("play continues after stop");
endmodule // ssc_sequencer_props
bind ssc_sequencer ssc_sequencer_props u_props (.clock(clock), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .seg_ready_i(seg_ready_i),
   .seg_valid_o(seg_valid_o), .seg_o(seg_o), .output_en_o(output_en_o), .playing_o(playing_o));
`default_nettype wire

/* ssc_player_model.sv */
// Segment player standing behind the sequencer's request stream.
// Assumes one clock with the sequencer; slow makes it stall after each take.
`timescale 1ns/100ps
`default_nettype none
module ssc_player_model (
   input wire logic clock,
   input wire logic rst,
   input wire logic slow,
   input wire logic seg_valid_o,
   output logic seg_ready_i,
   output logic seg_done_i
);
   logic [1:0] wait_q;
   // A slow player refuses for three cycles, so the two-entry buffer must hold
   always_ff @(posedge clock) begin
      if (rst) begin
         wait_q <= 2'h0;
         seg_done_i <= 1'b0;
      end else begin
         seg_done_i <= seg_valid_o && seg_ready_i;
         if (seg_valid_o && seg_ready_i && slow) wait_q <= 2'h3;
         else if (wait_q != 2'h0) wait_q <= wait_q - 2'h1;
      end
   end
   assign seg_ready_i = !rst && wait_q == 2'h0;
endmodule // ssc_player_model
`default_nettype wire

/* ssc_sequencer_test.sv */
// Self-checking bench for the segment sequencer.
// Assumes the player model and the bound port checker.
`timescale 1ns/100ps
`default_nettype none
`include "ssc_map.svh"
module ssc_sequencer_test;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [2:0] pins = 3'h0;
   logic slow = 1'b0;
   logic [31:0] reg_rdata;
   logic [31:0] rv;
   logic seg_done_i;
   logic seg_valid_o;
   logic seg_ready_i;
   logic output_en_o;
   logic playing_o;
   ssc_pkg::ssc_seg_req_t seg_o;
   int n_mismatch = 0;
   int n_checks = 0;
   logic [7:0] seen[$];
   logic [7:0] exp_q[$];
   logic [7:0] segs[8] = '{8'h2, 8'h1, 8'h3, 8'h4, 8'h5, 8'h6, 8'h7, 8'h8};
   logic [19:0] loops[8] = '{20'h2, 20'h4, 20'h2, 20'h1, 20'h1, 20'h1, 20'h1, 20'h1};
   always #2.5 clock = ~clock;
   always @(posedge clock) if (seg_valid_o && seg_ready_i) seen.push_back(seg_o.segment);
   ssc_sequencer dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .manual_trigger_button(pins[0]), .trig_in(pins[1]),
      .event_in(pins[2]), .seg_done_i(seg_done_i), .seg_valid_o(seg_valid_o), .seg_ready_i(seg_ready_i),
      .seg_o(seg_o), .output_en_o(output_en_o), .playing_o(playing_o));
   ssc_player_model player (.clock(clock), .rst(rst), .slow(slow), .seg_valid_o(seg_valid_o),
      .seg_ready_i(seg_ready_i), .seg_done_i(seg_done_i));
   // ------------------------------
   // Shared tasks
   // ------------------------------
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [3:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(posedge clock);
      rv = reg_rdata;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic takes(input int n);
      for (int i = 0; i < 3000 && seen.size() < n; i++) @(posedge clock);
      if (seen.size() < n) begin
         n_mismatch++;
         $display("wrong value takes expected %0d seen %0d", n, seen.size());
         wrap_up();
      end
   endtask
   function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] s, input logic a);
      return {27'h0, a, s, m};
   endfunction
   // Pins are synchronised inside, so the pulse is held well past two cycles
   task automatic fire(input int s);
      if (s == 3) wr(`SSC_REG_CMD, 32'h4);
      else begin
         pins[s] <= 1'b1;
         cyc(4);
         pins <= 3'h0;
         cyc(4);
      end
   endtask
   task automatic go(input logic [31:0] c);
      wr(`SSC_REG_CTRL, c);
      seen.delete();
      wr(`SSC_REG_CMD, 32'h1);
   endtask
   task automatic halt;
      slow <= 1'b0;
      cyc(6);
      wr(`SSC_REG_CMD, 32'h2);
      cyc(10);
   endtask
   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_regs;
      wr(`SSC_REG_REPEAT, 32'h0);
      rd(`SSC_REG_REPEAT);
      check("repeat floor", 32'h1, rv);
      wr(`SSC_REG_REPEAT, 32'h001e8480);
      rd(`SSC_REG_REPEAT);
      check("repeat ceiling", 32'h000f4240, rv);
      rd(4'hf);
      check("unmapped", 32'h0, rv);
      wr(`SSC_REG_TBL_ADDR, 32'h0);
      for (int i = 0; i < 8; i++) wr(`SSC_REG_TBL_DATA, {3'h0, 1'b0, segs[i], loops[i]});
   endtask
   task automatic t_out;
      check("enable at reset", 32'h0, 32'(output_en_o));
      wr(`SSC_REG_CTRL, 32'h20);
      check("enable on", 32'h1, 32'(output_en_o));
      wr(`SSC_REG_CMD, 32'h8);
      check("enable after recall", 32'h0, 32'(output_en_o));
   endtask
   task automatic t_auto;
      slow <= 1'b1;
      go(ctl(2'h0, 2'h3, 1'b0));
      takes(30);
      for (int i = 0; i < 30; i++) check("auto order", 32'(exp_q[i]), 32'(seen[i]));
      halt();
   endtask
   task automatic t_armed;
      go(ctl(2'h0, 2'h1, 1'b1));
      cyc(30);
      check("armed idle", 32'h0, 32'(seen.size()));
      fire(1);
      takes(3);
      check("armed first", 32'h2, 32'(seen[0]));
      halt();
   endtask
   task automatic t_once;
      wr(`SSC_REG_REPEAT, 32'h2);
      go(ctl(2'h1, 2'h1, 1'b0));
      cyc(40);
      check("once idle", 32'h0, 32'(seen.size()));
      fire(1);
      takes(26);
      cyc(200);
      check("once count", 32'd26, 32'(seen.size()));
      for (int i = 0; i < 26; i++) check("once order", 32'(exp_q[i]), 32'(seen[i]));
      halt();
   endtask
   task automatic t_stepped;
      for (int s = 0; s < 4; s++) begin
         go(ctl(2'h2, 2'(s), 1'b0));
         // Stepped mode leaves the armed state only on an advance event
         fire(s);
         cyc(60);
         check("step dwell", 32'h2, 32'(seen[$]));
         fire(s);
         cyc(60);
         check("step next", 32'h1, 32'(seen[$]));
         if (s == 3) begin
            repeat (7) begin
               fire(3);
               cyc(40);
            end
            check("step wrap", 32'h2, 32'(seen[$]));
         end
         halt();
      end
   endtask
   task automatic t_hier;
      logic [7:0] h[$];
      wr(`SSC_REG_TBL_ADDR, 32'h2);
      wr(`SSC_REG_TBL_DATA, {3'h1, 1'b0, segs[2], loops[2]});
      wr(`SSC_REG_SEQ_LOOPS, 32'h2);
      for (int p = 0; p < 2; p++)
         for (int r = 0; r < 3; r++)
            for (int l = 0; l < loops[r]; l++) h.push_back(segs[r]);
      for (int r = 3; r < 8; r++) h.push_back(segs[r]);
      go(ctl(2'h0, 2'h3, 1'b0));
      takes(21);
      for (int i = 0; i < 21; i++) check("hier order", 32'(h[i]), 32'(seen[i]));
      halt();
   endtask
   initial begin
      for (int p = 0; p < 3; p++)
         for (int r = 0; r < 8; r++)
            for (int l = 0; l < loops[r]; l++) exp_q.push_back(segs[r]);
      cyc(16);
      rst <= 1'b0;
      cyc(1);
      t_out();
      t_regs();
      t_auto();
      t_armed();
      t_once();
      t_stepped();
      t_hier();
      wrap_up();
   end
endmodule // ssc_sequencer_test
`default_nettype wire
